/* rtl/host_bus_pkg.sv */
/*
 host bus decode package: bus style and access type encodings, field
 positions of the host pins inside the synchroniser vector.
 assumes an 8-bit parallel host bus.
*/
package host_bus_pkg;
   localparam int data_width = 8;
   // bus styles: separate strobes or enable clock with direction
   typedef enum logic {style_strobe, style_enable} bus_style_type;
   // decoded access types
   typedef enum logic [2:0] {acc_none, acc_status_rd, acc_data_rd, acc_data_wr, acc_cmd_wr} access_type;
   localparam logic [7:0] data_reset = 8'h00;
   localparam logic [7:0] status_reset = 8'h00;
   // bit positions of the host pins inside the synchroniser vector
   localparam int pos_style = 11;
   localparam int pos_cs_n = 10;
   localparam int pos_sel = 9;
   localparam int pos_rd = 8;
   localparam int pos_wr = 7;
   // synchroniser value after reset: strobe style, deselected, strobes idle high
   localparam logic [11:0] pin_idle = 12'h580;
   localparam logic data7_idle = 1'b0;
endpackage

/* rtl/host_bus_decode.sv */
/*
 host-side parallel bus decode of a dot-matrix display controller.
 assumes the host pins are asynchronous to clk; they are synchronised
 with two flip-flops before any decode. one clock, one asynchronous active-low reset.
*/
// Functional notes
// - enable style: direction high reads, low writes
// - respond only while chip select low
// - select 0 read strobe: return status flag
// - select 1 read strobe: return display data
// - write: select 0 data, select 1 command
// - drive data bus only during read strobe
// - capture write data on write strobe rising
// - enable style: read pin is high enable
`timescale 1ns/1ps
module host_bus_decode
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // bus style strap
   input wire logic style_enable_mode,
   // host pins
   input wire logic cs_n,
   input wire logic cmd_data_select,
   input wire logic rd_n_or_en,
   input wire logic wr_n_or_dir,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   // core side
   input wire logic [7:0] status_flag,
   input wire logic [7:0] read_data,
   output logic status_rd_pulse,
   output logic data_rd_pulse,
   output logic data_wr_pulse,
   output logic cmd_wr_pulse,
   output logic [7:0] wr_data
);
   import host_bus_pkg::*;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [11:0] meta_ff;
   logic [11:0] sync_ff;
   logic [11:0] pins;
   assign pins = {style_enable_mode, cs_n, cmd_data_select, rd_n_or_en, wr_n_or_dir, data_in[6:0]};
   // data bit 7 carried separately to keep vectors short
   logic d7_meta_ff, d7_sync_ff;

   // two stage synchroniser on every host pin
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         // idle pin levels, so no false strobe edge follows reset
         meta_ff <= pin_idle;
         sync_ff <= pin_idle;
         d7_meta_ff <= data7_idle;
         d7_sync_ff <= data7_idle;
      end
      else
      begin
         meta_ff <= pins;
         sync_ff <= meta_ff;
         d7_meta_ff <= data_in[7];
         d7_sync_ff <= d7_meta_ff;
      end
   end

   // ----------------------------------------
   // decode
   // ----------------------------------------
   // synchronised pin levels picked out of the vector
   wire s_style = sync_ff[pos_style];
   wire s_cs_n = sync_ff[pos_cs_n];
   wire s_sel = sync_ff[pos_sel];
   wire s_rd = sync_ff[pos_rd];
   wire s_wr = sync_ff[pos_wr];
   wire [7:0] s_data = {d7_sync_ff, sync_ff[6:0]};
   wire selected = !s_cs_n;
   wire strobe_rd = !s_style && selected && !s_rd && s_wr;
   wire strobe_wr = !s_style && selected && s_rd && !s_wr;
   wire en_active = s_style && selected && s_rd;
   wire en_rd = en_active && s_wr;
   wire en_wr = en_active && !s_wr;
   wire read_now = strobe_rd || en_rd;
   logic wr_strobe_d_ff;
   logic en_wr_d_ff;
   logic rd_d_ff;
   logic wr_sel_ff;
   // rising edge of write strobe in strobe style, falling enable otherwise
   wire wr_done_strobe = wr_strobe_d_ff && !strobe_wr;
   wire wr_done_en = en_wr_d_ff && !en_wr;
   wire wr_done = wr_done_strobe || wr_done_en;
   wire rd_start = read_now && !rd_d_ff;

   // access state and captured data
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_strobe_d_ff <= 1'b0;
         en_wr_d_ff <= 1'b0;
         rd_d_ff <= 1'b0;
         wr_sel_ff <= 1'b0;
         wr_data <= data_reset;
         data_out <= data_reset;
         status_rd_pulse <= 1'b0;
         data_rd_pulse <= 1'b0;
         data_wr_pulse <= 1'b0;
         cmd_wr_pulse <= 1'b0;
      end
      else
      begin
         wr_strobe_d_ff <= strobe_wr;
         en_wr_d_ff <= en_wr;
         rd_d_ff <= read_now;
         if (strobe_wr || en_wr)
         begin
            wr_data <= s_data;
            wr_sel_ff <= s_sel;
         end
         if (read_now)
            data_out <= s_sel ? read_data : status_flag;
         status_rd_pulse <= rd_start && !s_sel;
         data_rd_pulse <= rd_start && s_sel;
         data_wr_pulse <= wr_done && !wr_sel_ff;
         cmd_wr_pulse <= wr_done && wr_sel_ff;
      end
   end

   // drivers on only while a read is in progress
   assign data_oe = read_now && rd_d_ff;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // pin pattern of an enable-style read, for the read timing check
   wire en_rd_pin = style_enable_mode && !cs_n && rd_n_or_en && wr_n_or_dir;

   // drivers on only if chip select was low at the pins two edges back
   property p_oe_needs_cs;
      @(posedge clk) disable iff (!rstn)
         data_oe |-> !$past(cs_n, 2);
   endproperty
   a_oe_needs_cs: assert property (p_oe_needs_cs) else $error("drivers on without chip select");

   // status pulse follows a select-low read and carries the status byte
   property p_status_sel;
      @(posedge clk) disable iff (!rstn)
         status_rd_pulse |-> !$past(cmd_data_select, 3) && (data_out == $past(status_flag));
   endproperty
   a_status_sel: assert property (p_status_sel) else $error("status read with wrong select");

   // data read pulse follows a select-high read and carries core data
   property p_data_rd_sel;
      @(posedge clk) disable iff (!rstn)
         data_rd_pulse |-> $past(cmd_data_select, 3) && (data_out == $past(read_data));
   endproperty
   a_data_rd_sel: assert property (p_data_rd_sel) else $error("data read with wrong select");

   // never both write types for one finished write
   property p_wr_one_hot;
      @(posedge clk) disable iff (!rstn)
         !(data_wr_pulse && cmd_wr_pulse);
   endproperty
   a_wr_one_hot: assert property (p_wr_one_hot) else $error("two write types at once");

   // drivers on only after a read pattern on the strobe pins
   property p_oe_only_read;
      @(posedge clk) disable iff (!rstn)
         data_oe |-> $past(wr_n_or_dir, 2) && ($past(rd_n_or_en, 2) == $past(style_enable_mode, 2));
   endproperty
   a_oe_only_read: assert property (p_oe_only_read) else $error("drivers on outside read");

   // strobe style: write strobe back high ends one write
   sequence s_wr_rise;
      strobe_wr ##1 !strobe_wr;
   endsequence

   // the rise raises a pulse and keeps the byte of the last strobe cycle
   property p_wr_capture;
      @(posedge clk) disable iff (!rstn)
         s_wr_rise |=> (data_wr_pulse || cmd_wr_pulse) && (wr_data == $past(data_in, 4));
   endproperty
   a_wr_capture: assert property (p_wr_capture) else $error("write strobe end not taken");

   // strobe style: select at the pins picks data or command
   property p_strobe_sel;
      @(posedge clk) disable iff (!rstn)
         s_wr_rise |=> (cmd_wr_pulse == $past(cmd_data_select, 4))
            && (data_wr_pulse != $past(cmd_data_select, 4));
   endproperty
   a_strobe_sel: assert property (p_strobe_sel) else $error("strobe write of wrong type");

   // enable style: direction low never turns the drivers on
   property p_enable_dir;
      @(posedge clk) disable iff (!rstn)
         ($past(style_enable_mode, 2) && $past(rd_n_or_en, 2) && !$past(wr_n_or_dir, 2)) |-> !data_oe;
   endproperty
   a_enable_dir: assert property (p_enable_dir) else $error("enable write decoded as read");

   // enable style: a held read pattern turns the drivers on
   property p_enable_rd;
      @(posedge clk) disable iff (!rstn)
         ($past(en_rd_pin, 2) && $past(en_rd_pin, 3)) |-> data_oe;
   endproperty
   a_enable_rd: assert property (p_enable_rd) else $error("enable read not driven");

   // enable low: nothing is decoded in enable style
   property p_enable_high;
      @(posedge clk) disable iff (!rstn)
         ($past(style_enable_mode, 2) && !$past(rd_n_or_en, 2)) |-> !data_oe && !en_wr;
   endproperty
   a_enable_high: assert property (p_enable_high) else $error("access without enable");

   // enable style: falling enable ends one write
   sequence s_en_wr_end;
      en_wr ##1 !en_wr;
   endsequence

   // the fall raises the write type that the select asked for
   property p_enable_cmd;
      @(posedge clk) disable iff (!rstn)
         s_en_wr_end |=> (cmd_wr_pulse == $past(cmd_data_select, 4))
            && (data_wr_pulse != $past(cmd_data_select, 4));
   endproperty
   a_enable_cmd: assert property (p_enable_cmd) else $error("enable write of wrong type");
endmodule

/* test/host_cpu_model.sv */
/*
 host cpu model: drives the parallel host pins in either bus style.
 assumes clk from the bench; sets the style strap before each access.
*/
`timescale 1ns/1ps
module host_cpu_model
(
   // clock
   input wire logic clk,
   // host pins
   output logic style_enable_mode,
   output logic cs_n,
   output logic cmd_data_select,
   output logic rd_n_or_en,
   output logic wr_n_or_dir,
   output logic [7:0] data_in
);
   // idle levels of every host pin, set once while reset is held
   task park;
      style_enable_mode <= 1'b0;
      cs_n <= 1'b1;
      cmd_data_select <= 1'b0;
      rd_n_or_en <= 1'b1;
      wr_n_or_dir <= 1'b1;
      data_in <= 8'h00;
   endtask
   // one access: idle, strobe held 5 cycles, idle with bus released
   task xfer(input logic st, cs, sel, rd, input logic [7:0] d);
      @(posedge clk);
      style_enable_mode <= st;
      rd_n_or_en <= ~st;
      wr_n_or_dir <= 1'b1;
      repeat (3) @(posedge clk);
      cs_n <= cs;
      cmd_data_select <= sel;
      data_in <= ~d;
      rd_n_or_en <= st | ~rd;
      wr_n_or_dir <= rd;
      // write byte settles late in the strobe, so only the end counts
      repeat (2) @(posedge clk);
      data_in <= d;
      repeat (3) @(posedge clk);
      rd_n_or_en <= ~st;
      wr_n_or_dir <= 1'b1;
      data_in <= ~d;
      repeat (6) @(posedge clk);
      cs_n <= 1'b1;
   endtask
endmodule

/* test/tb_top.sv */
/*
 top bench: decode block driven by the host cpu model.
 assumes 200 mhz clock and constant core values.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %h", $time, a); end end
module tb_top;
   import host_bus_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic st, cs_n, sel, en, dir, oe, p_sr, p_dr, p_dw, p_cw, oe_seen;
   logic [7:0] din, dout, wr_data, rdv;
   logic [7:0] status_flag = 8'h3c;
   logic [7:0] read_data = 8'hc5;
   logic [3:0] seen;
   logic clr = 1'b0;
   int fail_count = 0;
   int cmp_count = 0;
   always #2.5 clk = ~clk;
   host_cpu_model u_host (.clk(clk), .style_enable_mode(st), .cs_n(cs_n), .cmd_data_select(sel),
      .rd_n_or_en(en), .wr_n_or_dir(dir), .data_in(din));
   host_bus_decode u_dut (.clk(clk), .rstn(rstn), .style_enable_mode(st), .cs_n(cs_n),
      .cmd_data_select(sel), .rd_n_or_en(en), .wr_n_or_dir(dir), .data_in(din), .data_out(dout),
      .data_oe(oe), .status_flag(status_flag), .read_data(read_data), .status_rd_pulse(p_sr),
      .data_rd_pulse(p_dr), .data_wr_pulse(p_dw), .cmd_wr_pulse(p_cw), .wr_data(wr_data));
   // collect pulses and read data
   always @(posedge clk)
   begin
      seen <= clr ? 4'h0 : (seen | {p_cw, p_dw, p_dr, p_sr});
      oe_seen <= clr ? 1'b0 : (oe_seen | oe);
      if (clr)
         rdv <= 8'h00;
      else if (oe)
         rdv <= dout;
   end
   // one access and its judgement
   task run(input logic s, cs, a, rd, input logic [7:0] d);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      u_host.xfer(s, cs, a, rd, d);
      `CHK(seen, cs ? 4'h0 : 4'h1 << {~rd, a})
      `CHK(oe_seen, ~cs & rd)
      if (~cs & rd)
         `CHK(rdv, a ? read_data : status_flag)
      if (~cs & ~rd)
         `CHK(wr_data, d)
   endtask
   task t_strobe;
      for (int i = 0; i < 4; i++)
         run(1'b0, 1'b0, i[0], i[1], 8'h81 + 8'(i));
   endtask
   task t_enable;
      for (int i = 0; i < 4; i++)
         run(1'b1, 1'b0, i[0], i[1], 8'h42 + 8'(i));
   endtask
   task t_deselect;
      for (int i = 0; i < 4; i++)
         run(i[0], 1'b1, 1'b1, i[1], 8'h99);
   endtask
   task print_verdict;
      $display("compares %0d errors %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      u_host.park();
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_strobe();
      t_enable();
      t_deselect();
      print_verdict();
   end
   // watchdog
   initial
   begin
      #20000;
      fail_count++;
      print_verdict();
   end
endmodule
